// [design/qps_pkg.sv]
// Constants, encodings and types for the quad pot serial register slave.
// Assumes one 50 MHz system clock and synchronous serial pins.
package qps_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 50_000_000;
    localparam int NV_WRITE_MS  = 20;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
    localparam int NV_CNT_W     = 20;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_WIPER_LAST = 4'h3;
    localparam logic [3:0] ADDR_SCRATCH_A  = 4'h4;
    localparam logic [3:0] ADDR_SCRATCH_C  = 4'h6;
    localparam logic [3:0] ADDR_RESERVED   = 4'h7;
    localparam logic [3:0] ADDR_ACCESS     = 4'h8;
    localparam logic [3:0] ADDR_FIRST      = 4'h0;

    // ------------------------------------------------------------
    // Access control fields and reset values
    // ------------------------------------------------------------
    localparam int         ACC_VOL_BIT   = 7;
    localparam int         ACC_PD_BIT    = 6;
    localparam int         ACC_BUSY_BIT  = 5;
    localparam logic       VOL_SEL_RST   = 1'b0;
    localparam logic       PD_BIT_RST    = 1'b1;
    localparam logic [7:0] WIPER_RST     = 8'h40;
    localparam logic [7:0] NV_INIT       = 8'h40;
    localparam logic [7:0] SCRATCH_INIT  = 8'h00;

    // ------------------------------------------------------------
    // Serial protocol
    // ------------------------------------------------------------
    // Device code value is arbitrary
    localparam logic [3:0] DEV_CODE   = 4'hA;
    localparam logic [3:0] ID_LOW     = 4'h0;
    localparam logic [3:0] INSTR_READ = 4'hB;
    localparam logic [3:0] INSTR_WRITE = 4'hC;
    localparam logic [2:0] BIT_LAST   = 3'h7;

    typedef enum logic [5:0] {
        QPS_IDLE = 6'b00_0001,
        QPS_ID   = 6'b00_0010,
        QPS_CMD  = 6'b00_0100,
        QPS_WR   = 6'b00_1000,
        QPS_RD   = 6'b01_0000,
        QPS_SKIP = 6'b10_0000
    } qps_state_e;

endpackage : qps_pkg

// [design/qps_spi_if.sv]
// Byte level link between the serial shifter and the register control.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface qps_spi_if;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       frame_start;
    logic       frame_end;
    logic [7:0] tx_byte;
    logic       tx_load;
    logic       tx_en;
    logic       sdo_low;

    modport shifter (
        output rx_byte, rx_valid, frame_start, frame_end, sdo_low,
        input  tx_byte, tx_load, tx_en
    );
    modport ctrl (
        input  rx_byte, rx_valid, frame_start, frame_end, sdo_low,
        output tx_byte, tx_load, tx_en
    );
endinterface : qps_spi_if

// [design/qps_spi_shift.sv]
// Mode 0 serial shifter: bytes in on rising, bits out on falling clock.
// Assumes sck, sdi and cs_n are synchronous to clk and much slower.
`timescale 1ns/1ns
module qps_spi_shift
    import qps_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sck,
    input  wire logic sdi,
    input  wire logic cs_n,
    qps_spi_if.shifter bus
);
    logic       sck_q_r;
    logic       cs_q_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] rx_sh_r;
    logic [7:0] tx_sh_r;
    logic       sck_rise;
    logic       sck_fall;

    assign sck_rise = sck & ~sck_q_r & ~cs_n;
    assign sck_fall = ~sck & sck_q_r & ~cs_n;

    // ------------------------------------------------------------
    // Edge and frame detection
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_q_r         <= 1'b0;
            cs_q_r          <= 1'b0;
            bus.frame_start <= 1'b0;
            bus.frame_end   <= 1'b0;
        end else begin
            sck_q_r         <= sck;
            cs_q_r          <= cs_n;
            bus.frame_start <= cs_q_r & ~cs_n;
            bus.frame_end   <= cs_n & ~cs_q_r;
        end
    end

    // ------------------------------------------------------------
    // Receive, MSB first on rising edges
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_r    <= 3'h0;
            rx_sh_r      <= 7'h00;
            bus.rx_byte  <= 8'h00;
            bus.rx_valid <= 1'b0;
        end else begin
            bus.rx_valid <= 1'b0;
            if (cs_n) begin
                bit_cnt_r <= 3'h0;
            end else if (sck_rise) begin
                rx_sh_r   <= {rx_sh_r[5:0], sdi};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == BIT_LAST) begin
                    bus.rx_byte  <= {rx_sh_r, sdi};
                    bus.rx_valid <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit, MSB first on falling edges, open drain
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_sh_r     <= 8'h00;
            bus.sdo_low <= 1'b0;
        end else if (cs_n) begin
            bus.sdo_low <= 1'b0;
        end else if (bus.tx_load) begin
            tx_sh_r <= bus.tx_byte;
        end else if (sck_fall) begin
            bus.sdo_low <= bus.tx_en & ~tx_sh_r[7];
            tx_sh_r     <= {tx_sh_r[6:0], 1'b0};
        end
    end

endmodule : qps_spi_shift

// [design/qps_nv_timer.sv]
// Self-timed non-volatile write cycle; busy for NV_CYC clocks.
// Assumes start is a one-cycle pulse.
`timescale 1ns/1ns
module qps_nv_timer
    import qps_pkg::*;
#(
    parameter int NV_CYC = NV_WRITE_CYC
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic start,
    output logic      busy
);
    logic [NV_CNT_W-1:0] cnt_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            busy  <= 1'b0;
        end else if (start) begin
            cnt_r <= NV_CNT_W'(NV_CYC - 1);
            busy  <= 1'b1;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - NV_CNT_W'(1);
        end else begin
            busy  <= 1'b0;
        end
    end

endmodule : qps_nv_timer

// [design/qps_top.sv]
// Register logic of a quad digital potentiometer behind a mode 0 serial
// slave port, with power-up reload and a self-timed non-volatile write.
// Assumes serial pins synchronous to clk; analog arrays lie outside.
//
// Contract
// - Low seven wiper bits pick the tap
// - Wipers start at mid-scale 40h
// - Wipers then reload from power-up registers
// - Addresses 0 to 3 select channels 0-3
// - 4-6 scratch, 7 reserved, 8 access control
// - Power-up and wiper registers share addresses
// - Volatile-select bit routes low addresses
// - Power-up write also loads the wiper
// - Shutdown bit low forces shutdown, resets high
// - Normal only with pin and bit high
// - Shutdown grounds wipers, keeps settings
// - Serial port works during shutdown
// - Read-only busy flag during non-volatile write
// - Busy blocks wiper, power-up, control writes
// - Sample on rising, shift on falling
// - Bytes travel most significant bit first
// - First byte is the identification byte
// - Second byte: instruction high, address low
// - Only read and write instructions valid
// - Output released when deselected; standby once no write cycle pends or runs
// - Write pointer increments, wraps after six
// - Non-volatile write starts at select rise
// - Read streams registers, pointer wraps after six
`timescale 1ns/1ns
module qps_top
    import qps_pkg::*;
#(
    parameter int NV_CYC = NV_WRITE_CYC
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sck,
    input  wire logic        sdi,
    input  wire logic        cs_n,
    input  wire logic        power_down_n,
    output logic             sdo_o,
    output logic             sdo_oe,
    output logic [27:0]      wiper_tap,
    output logic             pot_shutdown,
    output logic             standby,
    output logic             nv_write_busy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    qps_spi_if   link ();
    qps_state_e  state_r;
    logic [3:0]  ptr_r;
    logic [7:0]  wiper_r    [4];
    logic [7:0]  pu_wiper_r [4];
    logic [7:0]  scratch_r  [3];
    logic        volatile_select_r;
    logic        pd_bit_r;
    logic        reload_pend_r;
    logic        nv_pend_r;
    logic        nv_start_r;
    logic        busy;
    logic [7:0]  tx_byte_r;
    logic        tx_load_r;
    logic        tx_en_r;
    logic        wr_strobe;
    logic        wr_low;
    logic        wr_nv_low;
    logic        wr_scratch;
    logic        wr_access;
    logic [7:0]  wr_data;
    logic [1:0]  wr_ch;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] ptr_next(input logic [3:0] p);
        if (p >= ADDR_SCRATCH_C) begin
            ptr_next = ADDR_FIRST;
        end else begin
            ptr_next = p + 4'h1;
        end
    endfunction : ptr_next

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic is_wiper(input logic [3:0] a);
        is_wiper = (a <= ADDR_WIPER_LAST);
    endfunction : is_wiper

    function automatic logic is_scratch(input logic [3:0] a);
        is_scratch = (a >= ADDR_SCRATCH_A)
                     && (a <= ADDR_SCRATCH_C);
    endfunction : is_scratch

    function automatic logic [1:0] scratch_idx(input logic [3:0] a);
        scratch_idx = 2'(a - ADDR_SCRATCH_A);
    endfunction : scratch_idx

    function automatic logic [7:0] read_reg(input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (is_wiper(a)) begin
            v = volatile_select_r ? wiper_r[a[1:0]]
                                  : pu_wiper_r[a[1:0]];
        end else if (is_scratch(a)) begin
            v = scratch_r[scratch_idx(a)];
        end else if (a == ADDR_ACCESS) begin
            v[ACC_VOL_BIT]  = volatile_select_r;
            v[ACC_PD_BIT]   = pd_bit_r;
            v[ACC_BUSY_BIT] = busy;
        end
        read_reg = v;
    endfunction : read_reg

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    qps_spi_shift u_shift (
        .clk    (clk),
        .resetn (resetn),
        .sck    (sck),
        .sdi    (sdi),
        .cs_n   (cs_n),
        .bus    (link)
    );

    qps_nv_timer #(
        .NV_CYC (NV_CYC)
    ) u_nv (
        .clk    (clk),
        .resetn (resetn),
        .start  (nv_start_r),
        .busy   (busy)
    );

    assign link.tx_byte = tx_byte_r;
    assign link.tx_load = tx_load_r;
    assign link.tx_en   = tx_en_r;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_strobe  = link.rx_valid && (state_r == QPS_WR);
    assign wr_data    = link.rx_byte;
    assign wr_ch      = ptr_r[1:0];
    assign wr_low     = wr_strobe && is_wiper(ptr_r)
                        && !busy;
    assign wr_nv_low  = wr_low && !volatile_select_r;
    assign wr_scratch = wr_strobe
                        && is_scratch(ptr_r);
    assign wr_access  = wr_strobe && (ptr_r == ADDR_ACCESS)
                        && !busy;

    // ------------------------------------------------------------
    // Frame sequencer and pointer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= QPS_IDLE;
            ptr_r     <= ADDR_FIRST;
            tx_byte_r <= 8'h00;
            tx_load_r <= 1'b0;
            tx_en_r   <= 1'b0;
        end else begin
            tx_load_r <= 1'b0;
            if (link.frame_end) begin
                state_r <= QPS_IDLE;
                tx_en_r <= 1'b0;
            end else if (link.frame_start) begin
                state_r <= QPS_ID;
                tx_en_r <= 1'b0;
            end else if (link.rx_valid) begin
                case (state_r)
                    QPS_ID: begin
                        if (link.rx_byte == {DEV_CODE, ID_LOW}) begin
                            state_r <= QPS_CMD;
                        end else begin
                            state_r <= QPS_SKIP;
                        end
                    end
                    QPS_CMD: begin
                        ptr_r <= link.rx_byte[3:0];
                        if (link.rx_byte[7:4] == INSTR_READ) begin
                            state_r   <= QPS_RD;
                            tx_byte_r <= read_reg(link.rx_byte[3:0]);
                            tx_load_r <= 1'b1;
                            tx_en_r   <= 1'b1;
                            ptr_r     <= ptr_next(link.rx_byte[3:0]);
                        end else if (link.rx_byte[7:4] == INSTR_WRITE) begin
                            state_r <= QPS_WR;
                        end else begin
                            state_r <= QPS_SKIP;
                        end
                    end
                    QPS_WR: begin
                        ptr_r <= ptr_next(ptr_r);
                    end
                    QPS_RD: begin
                        tx_byte_r <= read_reg(ptr_r);
                        tx_load_r <= 1'b1;
                        ptr_r     <= ptr_next(ptr_r);
                    end
                    QPS_SKIP: begin
                        state_r <= QPS_SKIP;
                    end
                    QPS_IDLE: begin
                        state_r <= QPS_IDLE;
                    end
                    default: begin
                        state_r <= QPS_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Wiper setting registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                wiper_r[i] <= WIPER_RST;
            end
            reload_pend_r <= 1'b1;
        end else if (reload_pend_r) begin
            reload_pend_r <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                wiper_r[i] <= pu_wiper_r[i];
            end
        end else if (wr_low) begin
            wiper_r[wr_ch] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Non-volatile registers and write cycle launch
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                pu_wiper_r[i] <= NV_INIT;
            end
            for (int i = 0; i < 3; i++) begin
                scratch_r[i] <= SCRATCH_INIT;
            end
            nv_pend_r  <= 1'b0;
            nv_start_r <= 1'b0;
        end else begin
            nv_start_r <= 1'b0;
            if (wr_nv_low) begin
                pu_wiper_r[wr_ch] <= wr_data;
                nv_pend_r         <= 1'b1;
            end
            if (wr_scratch) begin
                scratch_r[scratch_idx(ptr_r)] <= wr_data;
                nv_pend_r <= 1'b1;
            end
            if (link.frame_end && nv_pend_r) begin
                nv_start_r <= 1'b1;
                nv_pend_r  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Access control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            volatile_select_r <= VOL_SEL_RST;
            pd_bit_r          <= PD_BIT_RST;
        end else if (wr_access) begin
            volatile_select_r <= wr_data[ACC_VOL_BIT];
            pd_bit_r          <= wr_data[ACC_PD_BIT];
        end
    end

    // ------------------------------------------------------------
    // Tap outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wiper_tap <= {4{WIPER_RST[6:0]}};
        end else begin
            for (int i = 0; i < 4; i++) begin
                wiper_tap[i*7 +: 7] <= wiper_r[i][6:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Shutdown output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pot_shutdown <= 1'b0;
        end else begin
            pot_shutdown <= ~(power_down_n & pd_bit_r);
        end
    end

    // ------------------------------------------------------------
    // Standby output, low while selected and until write cycle ends
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            standby <= 1'b1;
        end else begin
            standby <= cs_n & ~busy & ~nv_pend_r & ~nv_start_r;
        end
    end

    // ------------------------------------------------------------
    // Write cycle busy output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nv_write_busy <= 1'b0;
        end else begin
            nv_write_busy <= busy;
        end
    end

    // ------------------------------------------------------------
    // Open drain serial output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdo_o  <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_o  <= 1'b0;
            sdo_oe <= link.sdo_low & ~cs_n;
        end
    end

endmodule : qps_top

// [verif/qps_top_sva.sv]
// Concurrent checks on the ports of the quad pot serial register slave.
// Assumes one clock domain and an asynchronous active low reset.
`timescale 1ns/1ns
module qps_top_sva
    import qps_pkg::*;
#(
    parameter int NV_CYC = NV_WRITE_CYC
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        sck,
    input wire logic        sdi,
    input wire logic        cs_n,
    input wire logic        power_down_n,
    input wire logic        sdo_o,
    input wire logic        sdo_oe,
    input wire logic [27:0] wiper_tap,
    input wire logic        pot_shutdown,
    input wire logic        standby,
    input wire logic        nv_write_busy
);
    // ------------------------------------------------------------
    // Busy length counter
    // ------------------------------------------------------------
    int busy_cnt;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 0;
        end else if (nv_write_busy) begin
            busy_cnt <= busy_cnt + 1;
        end else begin
            busy_cnt <= 0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    oe_released_a: assert property (cs_n [*4] |-> !sdo_oe)
        else $error("serial output driven while deselected");
    oe_drain_a: assert property (sdo_oe |-> !sdo_o)
        else $error("open drain output drives high");
    oe_on_low_a: assert property (!cs_n && $past(!cs_n, 4)
        && $changed(sdo_oe) |-> !sck && $past(!sck))
        else $error("serial output changed while clock high");
    standby_frame_a: assert property (!cs_n [*3] |-> !standby)
        else $error("standby during a frame");
    standby_idle_a: assert property ((cs_n && !nv_write_busy) [*6]
        |-> standby)
        else $error("no standby while idle");
    busy_standby_a: assert property (nv_write_busy [*2] |-> !standby)
        else $error("standby during write cycle");
    busy_start_a: assert property ($rose(nv_write_busy)
        |-> cs_n && $past(cs_n))
        else $error("write cycle started inside a frame");
    busy_len_a: assert property ($fell(nv_write_busy)
        |-> busy_cnt == NV_CYC)
        else $error("write cycle length wrong");
    pin_shutdown_a: assert property (!power_down_n [*3]
        |-> pot_shutdown)
        else $error("pin low without shutdown");
    shutdown_cause_a: assert property ($rose(pot_shutdown)
        |-> !$past(power_down_n) || !cs_n || !$past(cs_n, 4))
        else $error("shutdown without a cause");
endmodule : qps_top_sva

bind qps_top qps_top_sva #(.NV_CYC(NV_CYC)) u_sva (
    .clk(clk), .resetn(resetn), .sck(sck), .sdi(sdi), .cs_n(cs_n),
    .power_down_n(power_down_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .wiper_tap(wiper_tap), .pot_shutdown(pot_shutdown),
    .standby(standby), .nv_write_busy(nv_write_busy)
);

// [verif/qps_host_model.sv]
// Serial host model: mode 0 master that owns clock and select.
// Assumes an external pull-up on the open drain data line.
`timescale 1ns/1ns
module qps_host_model (
    output logic      sck,
    output logic      sdi,
    output logic      cs_n,
    input  wire logic clk,
    input  wire logic sdo_oe,
    input  wire logic sdo_o
);
    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    int         half = 5;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];

    initial begin
        sck  = 1'b0;
        sdi  = 1'b1;
        cs_n = 1'b1;
    end

    task automatic run;
        logic [7:0] r;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        rxq.delete();
        foreach (txq[k]) begin
            for (int i = 7; i >= 0; i--) begin
                sdi = txq[k][i];
                repeat (half) @(negedge clk);
                sck  = 1'b1;
                r[i] = sdo_oe ? sdo_o : 1'b1;
                repeat (half) @(negedge clk);
                sck = 1'b0;
            end
            rxq.push_back(r);
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        sdi  = ~sdi;
        repeat (4) @(negedge clk);
    endtask : run
endmodule : qps_host_model

// [verif/tb.sv]
// Self-checking bench for the quad pot serial register slave.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module tb;
    import qps_pkg::*;
    localparam int         NV = 2000;
    localparam logic [7:0] ID = {DEV_CODE, ID_LOW};
    logic             clk;
    logic             resetn;
    logic             power_down_n;
    wire logic        sck, sdi, cs_n, sdo_o, sdo_oe;
    wire logic        pot_shutdown, standby, nv_write_busy;
    wire logic [27:0] wiper_tap;
    int               n_errors = 0;
    int               checks_done = 0;
    logic [7:0]       q[$];

    qps_top #(.NV_CYC(NV)) DUT (.clk(clk), .resetn(resetn), .sck(sck),
        .sdi(sdi), .cs_n(cs_n), .power_down_n(power_down_n), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .wiper_tap(wiper_tap), .pot_shutdown(pot_shutdown),
        .standby(standby), .nv_write_busy(nv_write_busy));
    qps_host_model host (.sck(sck), .sdi(sdi), .cs_n(cs_n), .clk(clk),
        .sdo_oe(sdo_oe), .sdo_o(sdo_o));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input string w, input logic [27:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] id, ins, input logic [7:0] d[$]);
        host.txq.delete();
        host.txq.push_back(id);
        host.txq.push_back(ins);
        foreach (d[k]) host.txq.push_back(d[k]);
        host.run();
        q = host.rxq;
    endtask : xfer

    task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
        xfer(ID, {INSTR_WRITE, a}, d);
    endtask : wr

    task automatic rdchk(input string w, input logic [3:0] a, logic [7:0] e);
        xfer(ID, {INSTR_READ, a}, '{8'h00});
        chk(w, e, q[2]);
    endtask : rdchk

    task automatic wait_idle;
        for (int i = 0; i < 2 * NV && nv_write_busy !== 1'b0; i++)
            @(negedge clk);
        chk("busy end", 0, nv_write_busy);
    endtask : wait_idle

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        resetn = 1'b0;
        power_down_n = 1'b1;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        chk("taps", {4{7'h40}}, wiper_tap);
        chk("standby", 1, standby);
        chk("shutdown", 0, pot_shutdown);
        rdchk("control", ADDR_ACCESS, 8'h40);
        rdchk("pu2", 4'h2, NV_INIT);
        wr(4'h2, '{8'h77});
        chk("busy", 1, nv_write_busy);
        chk("standby busy", 0, standby);
        chk("tap2", 7'h77, wiper_tap[20:14]);
        rdchk("busy bit", ADDR_ACCESS, 8'h60);
        wr(ADDR_ACCESS, '{8'h80});
        wr(4'h1, '{8'h11});
        wait_idle();
        rdchk("control kept", ADDR_ACCESS, 8'h40);
        chk("tap1 kept", 7'h40, wiper_tap[13:7]);
        wr(ADDR_ACCESS, '{8'hDF});
        rdchk("control low", ADDR_ACCESS, 8'hC0);
        wr(4'h0, '{8'h00, 8'h7F, 8'h12, 8'h34});
        chk("taps vol", {7'h34, 7'h12, 7'h7F, 7'h00}, wiper_tap);
        chk("no nv", 0, nv_write_busy);
        rdchk("wiper3", 4'h3, 8'h34);
        wr(4'h5, '{8'hA5, 8'h5A, 8'h2B});
        chk("tap0 wrap", 7'h2B, wiper_tap[6:0]);
        wait_idle();
        xfer(ID, {INSTR_READ, 4'h5}, '{8'h00, 8'h00, 8'h00});
        chk("rd wrap", {8'hA5, 8'h5A, 8'h2B}, {q[2], q[3], q[4]});
        rdchk("reserved", ADDR_RESERVED, 8'h00);
        host.half = 9;
        for (int m = 0; m < 4; m++) begin
            power_down_n = m[0];
            wr(ADDR_ACCESS, '{{1'b0, m[1], 6'b0}});
            chk("mode", m != 3, pot_shutdown);
            rdchk("acr sd", ADDR_ACCESS, {1'b0, m[1], 6'b0});
        end
        host.half = 5;
        chk("taps kept", {7'h34, 7'h12, 7'h7F, 7'h2B}, wiper_tap);
        rdchk("pu0", 4'h0, 8'h40);
        rdchk("pu2 kept", 4'h2, 8'h77);
        for (int k = 0; k < 17; k++) begin
            if (k != 11 && k != 12) begin
                xfer(k == 16 ? ID ^ 8'h01 : ID,
                     k == 16 ? {INSTR_WRITE, 4'h0} : {k[3:0], 4'h0}, '{8'h11});
                chk("released", 8'hFF, q[2]);
                chk("no nv bad", 0, nv_write_busy);
            end
        end
        chk("taps bad", {7'h34, 7'h12, 7'h7F, 7'h2B}, wiper_tap);
        conclude();
    end
endmodule : tb
